// ===== interval_pwm_timer.sv
// Purpose: 8-bit interval / square-wave / PWM timer with two compares
// Assumes: Count-clock ticks arrive as one-cycle pulses on clk_i
// Notes: Mode register bits: 0 output enable, 1 level, 2 PWM, 6:4 clock select, 7 enable
// Operation
// RQ1 - Interval match interrupts and clears counter
// RQ2 - Interval mode ignores duty compare
// RQ3 - Output enable gives 50% square wave
// RQ4 - Interval match toggles, clears, interrupts together
// RQ5 - Counting starts within one clock
// RQ6 - Match interval is N plus one
// RQ7 - Disable forces interrupt and output inactive
// RQ8 - PWM period match first, sets active
// RQ9 - Duty match sets inactive, no clear
// RQ10 - PWM cycle N+1, width M+1
// RQ11 - Software keeps period fixed while counting
// RQ12 - Duty writes buffered until old match
// RQ13 - Transfer needs three count clocks
// RQ14 - Duty writes accepted any time
// RQ15 - Software rewrites duty before restart
// RQ16 - Software keeps duty below period
// RQ17 - PWM start masks one count clock
// RQ18 - Clock select picks count source
// RQ19 - Mode register resets zero, bit writable; the code takes whole-byte writes only
// RQ20 - Direction resets ones, clear to drive
// RQ21 - Level select sets inactive polarity
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "tmr_defines.svh"
module interval_pwm_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input var tmr_pkg::bus_req_s bus_i,
  output logic [7:0] rdata_o,
  // Count clock sources, one-cycle ticks
  input wire logic [7:0] cnt_src_i,
  // Events and pin
  output logic match_interrupt_o,
  output logic shared_port_pin_o,
  output logic shared_port_pin_oe_o
);
  import tmr_pkg::*;

  logic [7:0] mode_r;
  logic [7:0] period_compare_r;
  logic [7:0] duty_buf_r;
  logic [7:0] duty_compare_r;
  logic duty_pend_r;
  logic [1:0] pend_age_r;
  logic [7:0] port_dir_r;
  logic [7:0] port_out_r;
  logic [7:0] count_r;
  logic out_r;
  logic irq_r;
  logic mask_r;
  logic en_d_r;
  cmp_state_e state_r;
  logic tick;
  logic en;
  logic pwm;
  logic lev;
  logic start;
  logic per_hit;
  logic duty_hit;
  logic xfer;

  assign en = mode_r[`BIT_EN];
  assign pwm = mode_r[`BIT_PWM];
  assign lev = mode_r[`BIT_LEV];
  assign start = en && !en_d_r;
  assign tick = en && cnt_src_i[mode_r[`BIT_CKS+:3]]; // RQ18
  assign per_hit = tick && !mask_r && (state_r == ST_PERIOD) &&
                   (count_r == period_compare_r); // RQ1 RQ8
  assign duty_hit = tick && !mask_r && pwm && (state_r == ST_DUTY) &&
                    (count_r == duty_compare_r); // RQ2 RQ9
  assign xfer = duty_hit && duty_pend_r && (pend_age_r >= `DUTY_XFER_MIN); // RQ12 RQ13

  // Mode register, whole-byte writes; single bits by read-modify-write
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r <= `MODE_RST; // RQ19
    end else if (bus_i.wr && bus_i.addr == `ADDR_MODE) begin
      mode_r <= bus_i.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      period_compare_r <= `CMP_RST;
      port_dir_r <= `PORTDIR_RST; // RQ20
      port_out_r <= `PORTOUT_RST;
    end else if (bus_i.wr) begin
      if (bus_i.addr == `ADDR_PERIOD) begin
        period_compare_r <= bus_i.wdata; // RQ11
      end
      if (bus_i.addr == `ADDR_PORTDIR) begin
        port_dir_r <= bus_i.wdata;
      end
      if (bus_i.addr == `ADDR_PORTOUT) begin
        port_out_r <= bus_i.wdata;
      end
    end
  end

  // Duty buffer: write lands in the buffer, counter never disturbed
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      duty_buf_r <= `CMP_RST;
      duty_pend_r <= 1'b0;
    end else if (bus_i.wr && bus_i.addr == `ADDR_DUTY) begin
      duty_buf_r <= bus_i.wdata; // RQ14
      duty_pend_r <= 1'b1;
    end else if (xfer) begin
      duty_pend_r <= 1'b0;
    end
  end

  // Ticks since last duty write; a rewrite restarts the age
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_age_r <= 2'h0;
    end else if (bus_i.wr && bus_i.addr == `ADDR_DUTY) begin
      pend_age_r <= 2'h0; // RQ13
    end else if (tick && pend_age_r != 2'h3) begin
      pend_age_r <= pend_age_r + 2'h1;
    end
  end

  // Active duty loads when stopped, else only at an old-value match
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      duty_compare_r <= `CMP_RST;
    end else if (!en && duty_pend_r) begin
      duty_compare_r <= duty_buf_r; // RQ15
    end else if (xfer) begin
      duty_compare_r <= duty_buf_r; // RQ12
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= en;
    end
  end

  // PWM start swallows the first count tick
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_r <= 1'b0;
    end else if (!en) begin
      mask_r <= 1'b0;
    end else if (start) begin
      mask_r <= pwm; // RQ17
    end else if (tick) begin
      mask_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_IDLE;
    end else if (!en) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: state_r <= ST_PERIOD; // RQ5 RQ8
        ST_PERIOD: if (per_hit && pwm) begin
          state_r <= ST_DUTY; // RQ8
        end
        ST_DUTY: if (duty_hit) begin
          state_r <= ST_PERIOD; // RQ9
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Counter runs 0..N, so a period spans N+1 ticks
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_r <= 8'h00;
    end else if (!en || state_r == ST_IDLE) begin
      count_r <= 8'h00;
    end else if (per_hit) begin
      count_r <= 8'h00; // RQ1 RQ4 RQ6 RQ10
    end else if (tick && !mask_r) begin
      count_r <= count_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= en && per_hit; // RQ1 RQ4 RQ7
    end
  end

  // Timer output, held at its inactive level while stopped
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_r <= 1'b0;
    end else if (!en) begin
      out_r <= 1'b0; // RQ7
    end else if (per_hit) begin
      out_r <= pwm ? 1'b1 : !out_r; // RQ3 RQ4 RQ8
    end else if (duty_hit) begin
      out_r <= 1'b0; // RQ9 RQ10
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        `ADDR_MODE: rdata_o <= mode_r;
        `ADDR_PERIOD: rdata_o <= period_compare_r;
        `ADDR_DUTY: rdata_o <= duty_buf_r;
        `ADDR_PORTDIR: rdata_o <= port_dir_r;
        `ADDR_PORTOUT: rdata_o <= port_out_r;
        `ADDR_STATUS: rdata_o <= count_r;
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  assign match_interrupt_o = irq_r;
  // Pin drives only with direction bit 0; level select flips polarity of the timer output, not of the port latch
  assign shared_port_pin_oe_o = !port_dir_r[0]; // RQ20
  assign shared_port_pin_o = mode_r[`BIT_OE] ? ((out_r && en) ^ lev)
                                             : port_out_r[0]; // RQ3 RQ21

  property p_irq_clears;
    @(posedge clk_i) disable iff (!resetn_i)
      per_hit |=> (count_r == 8'h00) && irq_r;
  endproperty
  a_irq_clears: assert property (p_irq_clears) else $error("match lost"); // RQ1

  property p_no_duty_interval;
    @(posedge clk_i) disable iff (!resetn_i)
      (en && !pwm && !per_hit) |=> $stable(out_r);
  endproperty
  a_no_duty_interval: assert property (p_no_duty_interval) else $error("duty in interval"); // RQ2

  property p_toggle;
    @(posedge clk_i) disable iff (!resetn_i)
      (per_hit && !pwm && en) |=> (out_r != $past(out_r));
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle"); // RQ4

  property p_start;
    @(posedge clk_i) disable iff (!resetn_i)
      start |=> (state_r == ST_PERIOD);
  endproperty
  a_start: assert property (p_start) else $error("slow start"); // RQ5

  property p_stop;
    @(posedge clk_i) disable iff (!resetn_i)
      $fell(en) |-> ##1 (!irq_r && !out_r);
  endproperty
  a_stop: assert property (p_stop) else $error("stop not inactive"); // RQ7

  property p_stop_idle;
    @(posedge clk_i) disable iff (!resetn_i)
      !en |=> (state_r == ST_IDLE) && (count_r == 8'h00);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stopped counter moved"); // RQ7

  property p_count_bound;
    @(posedge clk_i) disable iff (!resetn_i)
      en |-> (count_r <= period_compare_r);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("count past period"); // RQ6

  property p_pwm_set;
    @(posedge clk_i) disable iff (!resetn_i)
      (per_hit && pwm) |=> out_r && (state_r == ST_DUTY || !en);
  endproperty
  a_pwm_set: assert property (p_pwm_set) else $error("pwm set"); // RQ8

  property p_pwm_clr;
    @(posedge clk_i) disable iff (!resetn_i)
      (duty_hit && en) |=> !out_r && !irq_r && count_r != 8'h00 || $past(count_r) == 8'hff;
  endproperty
  a_pwm_clr: assert property (p_pwm_clr) else $error("pwm clear"); // RQ9

  property p_xfer_age;
    @(posedge clk_i) disable iff (!resetn_i)
      (en && $past(en) && $changed(duty_compare_r)) |->
        $past(duty_hit) && ($past(pend_age_r) == 2'h3);
  endproperty
  a_xfer_age: assert property (p_xfer_age) else $error("early transfer"); // RQ13

  property p_mask;
    @(posedge clk_i) disable iff (!resetn_i)
      (start && pwm) |=> (count_r == 8'h00) && !out_r;
  endproperty
  a_mask: assert property (p_mask) else $error("no mask"); // RQ17
endmodule // interval_pwm_timer
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench for the interval and PWM timer
// Assumes: Selected count source ticks every second clock
// Notes: Pulse widths are measured in clocks between pin edges
`timescale 1ns/1ns
`default_nettype none
`include "tmr_defines.svh"
module testbench;
  import tmr_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ph = 1'b0;
  bus_req_s bus_i = '0;
  logic [7:0] rdata_o, d, n, m, m2;
  logic [7:0] cnt_src_i = 8'h00;
  logic [7:0] sel = 8'h00;
  logic irq, pin, oe;
  logic [15:0] rnd = 16'h004b;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int nirq = 0;
  int t0, t1, t2, t3, tw, k;
  interval_pwm_timer i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .cnt_src_i(cnt_src_i), .match_interrupt_o(irq),
    .shared_port_pin_o(pin), .shared_port_pin_oe_o(oe));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // Unselected sources tick every clock: a wrong select halves the interval
  always @(posedge clk_i) begin
    ph <= ~ph;
    cnt_src_i <= ph ? 8'hff : ~(8'h01 << sel);
    cyc <= cyc + 1;
  end
  always @(negedge clk_i) if (irq === 1'b1) nirq <= nirq + 1;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    bus_i <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_i);
    bus_i <= '0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_i);
    bus_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    bus_i <= '0;
    @(negedge clk_i);
    v = rdata_o;
  endtask
  // Bounded wait for irq (w=0) or pin (w=1) at level l
  task automatic waitl(input bit w, input logic l, output int t);
    int i;
    for (i = 0; i < 1500; i++) begin
      @(negedge clk_i);
      if ((w ? pin : irq) === l) break;
    end
    if (i == 1500) num_errors++;
    t = cyc;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(`ADDR_MODE, d);
    chk(16'(d), 16'(`MODE_RST));
    rd(`ADDR_PORTDIR, d);
    chk(16'(d), 16'(`PORTDIR_RST));
    chk(16'(oe), 16'h0);
    rd(3'h6, d);
    chk(16'(d), 16'h0);
    // Timer output off: pin follows the port latch
    wr(`ADDR_PORTOUT, 8'h01);
    @(negedge clk_i);
    chk(16'(pin), 16'h1);
    wr(`ADDR_PORTDIR, 8'hfe);
    wr(`ADDR_MODE, 8'h03);
    rd(`ADDR_MODE, d);
    chk(16'(d), 16'h3);
    chk(16'({oe, pin}), 16'h3);
    for (k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      n = (k == 0) ? 8'h01 : {4'h0, rnd[3:0]} + 8'h01;
      sel = 8'(k);
      wr(`ADDR_PERIOD, n);
      wr(`ADDR_DUTY, rnd[15:8]);
      wr(`ADDR_MODE, {1'b1, k[2:0], 4'h1});
      t0 = cyc;
      waitl(0, 1'b1, t1);
      chk(16'(t1 - t0 <= 2 * n + 4), 16'h1);
      @(negedge clk_i);
      chk(16'(pin), 16'h1);
      waitl(0, 1'b1, t2);
      chk(16'(t2 - t1), 16'(2 * n + 2));
      @(negedge clk_i);
      chk(16'(pin), 16'h0);
      waitl(0, 1'b1, t2);
      wr(`ADDR_MODE, 8'h01);
      @(negedge clk_i);
      chk(16'({irq, pin}), 16'h0);
    end
    for (k = 0; k < 5; k++) begin
      rnd = lfsr(rnd);
      n = (k == 0) ? 8'hff : {3'h0, rnd[4:0]} + 8'h14;
      m = (k == 0) ? 8'hfe : n - 8'h06 - {5'h0, rnd[7:5]};
      m2 = {4'h0, rnd[11:8]} + 8'h03;
      sel = {5'h0, rnd[14:12]};
      wr(`ADDR_DUTY, m);
      wr(`ADDR_PERIOD, n);
      wr(`ADDR_MODE, {1'b1, rnd[14:12], 4'h5});
      tw = cyc;
      repeat (2) @(negedge clk_i);
      chk(16'(pin), 16'h0);
      waitl(1, 1'b1, t0);
      // Masked first tick makes the first period one tick longer
      chk(16'(t0 - tw >= 2 * n + 5 && t0 - tw <= 2 * n + 6), 16'h1);
      t3 = nirq;
      waitl(1, 1'b0, t1);
      chk(16'(t1 - t0), 16'(2 * m + 2));
      waitl(1, 1'b1, t2);
      chk(16'(t2 - t0), 16'(2 * n + 2));
      chk(16'(nirq - t3), 16'h1);
      wr(`ADDR_DUTY, m2);
      waitl(1, 1'b0, t1);
      chk(16'(t1 - t2), 16'(2 * m + 2));
      waitl(1, 1'b1, t0);
      chk(16'(t0 - t2), 16'(2 * n + 2));
      // Late write lands just before the match, so it must wait a cycle
      repeat (2 * m2 - 4) @(negedge clk_i);
      wr(`ADDR_DUTY, m);
      waitl(1, 1'b0, t1);
      chk(16'(t1 - t0), 16'(2 * m2 + 2));
      waitl(1, 1'b1, t2);
      waitl(1, 1'b0, t1);
      chk(16'(t1 - t2), 16'(2 * m2 + 2));
      waitl(1, 1'b1, t0);
      waitl(1, 1'b0, t1);
      chk(16'(t1 - t0), 16'(2 * m + 2));
      waitl(1, 1'b1, t0);
      wr(`ADDR_MODE, 8'h05);
      @(negedge clk_i);
      chk(16'({irq, pin}), 16'h0);
    end
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire

// ===== tmr_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the timer
// Assumes: Register indices on a plain byte-wide port
// Notes: Definitions only
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
`define ADDR_MODE 3'h0
`define ADDR_PERIOD 3'h1
`define ADDR_DUTY 3'h2
`define ADDR_PORTDIR 3'h3
`define ADDR_PORTOUT 3'h4
`define ADDR_STATUS 3'h5
`define MODE_RST 8'h00
`define PORTDIR_RST 8'hff
`define PORTOUT_RST 8'h00
`define CMP_RST 8'h00
`define BIT_OE 0
`define BIT_LEV 1
`define BIT_PWM 2
`define BIT_CKS 4
`define BIT_EN 7
`define DUTY_XFER_MIN 2'h3
`endif

// ===== tmr_pkg.sv
// Purpose: Types shared by the timer
// Assumes: Nothing
// Notes: Bus carrier struct
package tmr_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PERIOD = 3'b010,
    ST_DUTY = 3'b100
  } cmp_state_e;
endpackage
